// ### logic/synth_dev.sv
// synthesizer control logic: serial registers, double buffering, hop, sdm, fast lock
//
// Contract
// - host first sets all power-down bits
// - host grounds pump outputs, waits 10 ms
// - host clears test modes, initializes mode register
// - host picks variant A or variant B
// - host programs three timers in order
// - host writes phase, divider config, channel
// - release pump, clear power-down, rewrite channel
// - variant B delays hop sixteen cycles
// - variant A channel values load next cycle
// - config and phase shadowed until channel
// - phase steps are 360 over modulus
// - channel write starts fast lock sequence
// - sdm seeded with phase per channel
// - host writes phase before channel
// - boost bit adds quarter pump current
// - host may change reference divider
// - channel register always written last
// - shadow writes never disturb running synthesizer
// - shift on rising clock, latch on strobe
// - three select bits choose the register
`timescale 1ns/1ps
`include "synth_link_cfg.svh"
module synth_dev
    import synth_link_pkg::*;
#(
    parameter int unsigned HOP_DELAY = `HOP_DELAY_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    synth_link_if.dev        link,
    output logic [9:0]       n_div,
    output logic [11:0]      mod_act,
    output logic [3:0]       rdiv_act,
    output logic             presc_sel,
    output logic [7:0]       cp_current,
    output logic             loop_sw_closed,
    output logic             damp_sw_closed,
    output logic             cp_grounded,
    output logic             power_down,
    output logic             ld_thresh_10ns,
    output logic             hop_pending
);

    generate
        if (HOP_DELAY < 1 || HOP_DELAY > 255) begin : g_chk
            $error("HOP_DELAY must be 1..255");
        end
    endgenerate

    localparam logic [7:0] DLY_LOAD = 8'(HOP_DELAY);

    // =====================================================
    // functions
    // =====================================================

    // one phase-detector step of the modulator: next accumulator and carry
    function automatic logic [12:0] sdm_step(
        input logic [11:0] acc,
        input logic [11:0] fraction_numerator,
        input logic [11:0] modv
    );
        logic [12:0] sum;
        sum = {1'b0, acc} + {1'b0, fraction_numerator};
        if (sum >= {1'b0, modv}) begin
            sdm_step = {1'b1, 12'(sum - {1'b0, modv})};
        end else begin
            sdm_step = {1'b0, sum[11:0]};
        end
    endfunction

    // pump current in units of the final current, boost adds a quarter
    function automatic logic [7:0] cp_level(
        input logic [2:0] shift,
        input logic       boost
    );
        logic [7:0] base;
        base = `CP_FULL >> shift;
        cp_level = base + (boost ? (base >> 2) : 8'h00);
    endfunction

    // =====================================================
    // link clock domain: serial input register
    // =====================================================
    logic [23:0] shift_reg;

    always_ff @(posedge link.sclk or negedge nrst) begin
        if (!nrst) begin
            shift_reg <= 24'h000000;
        end else begin
            shift_reg <= {shift_reg[22:0], link.sdata};
        end
    end

    // =====================================================
    // reference clock domain
    // =====================================================
    dev_state_s s_reg;
    dev_state_s s_next;

    logic        latch_evt;
    logic [23:0] w;
    logic [12:0] sdm_r;

    always_comb begin
        s_next = s_reg;
        s_next.le_s1 = link.latch_strobe;
        s_next.le_s2 = s_reg.le_s1;
        s_next.le_s3 = s_reg.le_s2;
        latch_evt = s_reg.le_s2 & ~s_reg.le_s3;
        // the word is quiet while the strobe is high, so sampling it here is safe
        w = shift_reg;
        sdm_r = sdm_step(s_reg.acc, s_reg.fraction_numerator_a, s_reg.mod_a);

        // modulator runs every cycle unless powered down
        if (s_reg.pd == 5'h00) begin
            s_next.acc = sdm_r[11:0];
            s_next.n_div = 10'({1'b0, s_reg.int_a} + {9'h000, sdm_r[12]});
        end

        // fast lock timers, counted in reference cycles
        if (s_reg.fl_run) begin
            s_next.fl_cnt = (s_reg.fl_cnt == 8'hFF) ? 8'hFF : s_reg.fl_cnt + 8'h01;
            if (s_next.fl_cnt >= s_reg.t_sw12) begin
                s_next.sw12 = 1'b0;
            end
            if (s_next.fl_cnt >= s_reg.t_sw3) begin
                s_next.sw3 = 1'b0;
            end
            if (s_reg.fl_cnt >= s_reg.t_icp && s_reg.cp_sh != 3'(`CP_RAMP_STEPS)) begin
                s_next.cp_sh = s_reg.cp_sh + 3'h1;
            end
            if (!s_next.sw12 && !s_next.sw3 && s_next.cp_sh == 3'(`CP_RAMP_STEPS)) begin
                s_next.fl_run = 1'b0;
            end
        end

        // pending hop: apply buffered settings together
        if (s_reg.pend) begin
            if (s_reg.dly == 8'h00) begin
                s_next.pend = 1'b0;
                s_next.int_a = s_reg.chan[`INT_MSB:`INT_LSB];
                s_next.fraction_numerator_a = s_reg.chan[`FRACTION_NUMERATOR_MSB:`FRACTION_NUMERATOR_LSB];
                s_next.mod_a = s_reg.cfg_sh[`FRACTION_NUMERATOR_MSB:`FRACTION_NUMERATOR_LSB];
                s_next.rdiv_a = s_reg.cfg_sh[`RDIV_MSB:`RDIV_LSB];
                s_next.presc_a = s_reg.cfg_sh[`PRESC_BIT];
                s_next.boost_a = s_reg.cfg_sh[`BOOST_BIT];
                // seeding with the phase offsets the sequence by phase/mod of a cycle
                s_next.acc = s_reg.ph_sh;
                s_next.fl_cnt = 8'h00;
                s_next.fl_run = 1'b1;
                s_next.sw12 = 1'b1;
                s_next.sw3 = 1'b1;
                s_next.cp_sh = 3'h0;
            end else begin
                s_next.dly = s_reg.dly - 8'h01;
            end
        end

        // word latched on the strobe edge goes to the selected register
        if (latch_evt) begin
            case (w[2:0])
                `SEL_CHAN: begin
                    s_next.chan = w;
                    s_next.pend = 1'b1;
                    // mode other than the 10 ns threshold keeps the hop delay
                    s_next.dly = (s_reg.mode == `MODE_LD10) ? 8'h00 : DLY_LOAD;
                end
                `SEL_CFG: begin
                    s_next.cfg_sh = w;
                end
                `SEL_PHASE: begin
                    s_next.ph_sh = w[`FRACTION_NUMERATOR_MSB:`FRACTION_NUMERATOR_LSB];
                end
                `SEL_FUNC: begin
                    s_next.rel = w[`FN_RELEASE_BIT];
                end
                `SEL_TIMER: begin
                    case (w[`TMR_SEL_MSB:`TMR_SEL_LSB])
                        `TMR_SW12: s_next.t_sw12 = w[`TMR_VAL_MSB:`TMR_VAL_LSB];
                        `TMR_SW3:  s_next.t_sw3 = w[`TMR_VAL_MSB:`TMR_VAL_LSB];
                        `TMR_ICP:  s_next.t_icp = w[`TMR_VAL_MSB:`TMR_VAL_LSB];
                        default:   s_next.test = s_reg.test;
                    endcase
                end
                `SEL_PD: begin
                    s_next.pd = w[`PD_MSB:`PD_LSB];
                end
                `SEL_MODE: begin
                    s_next.mode = w[`MODE_MSB:`MODE_LSB];
                end
                default: begin
                    s_next.test = w[15:0];
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.pd <= `PD_RESET;
            s_reg.mod_a <= `MOD_RESET;
            s_reg.cfg_sh <= {9'h000, `MOD_RESET, 3'h1};
        end else begin
            s_reg <= s_next;
        end
    end

    // =====================================================
    // outputs
    // =====================================================
    assign n_div = s_reg.n_div;
    assign mod_act = s_reg.mod_a;
    assign rdiv_act = s_reg.rdiv_a;
    assign presc_sel = s_reg.presc_a;
    assign cp_current = cp_level(s_reg.cp_sh, s_reg.boost_a);
    assign loop_sw_closed = s_reg.sw12;
    assign damp_sw_closed = s_reg.sw3;
    assign cp_grounded = ~s_reg.rel;
    assign power_down = |s_reg.pd;
    assign ld_thresh_10ns = (s_reg.mode == `MODE_LD10);
    assign hop_pending = s_reg.pend;
    assign link.diag_out = s_reg.fl_run;

endmodule

// ### logic/synth_host.sv
// host end: power-up sequence and hop writes over the three-wire link
`timescale 1ns/1ps
`include "synth_link_cfg.svh"
module synth_host
    import synth_link_pkg::*;
#(
    parameter int unsigned SCLK_HALF  = `SCLK_HALF_CYCLES,
    parameter int unsigned STROBE_CYC = `STROBE_CYCLES,
    parameter int unsigned WAIT_CYC   = `INIT_WAIT_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    synth_link_if.host       link,
    input  wire logic        start_init,
    input  wire logic        variant_b,
    output logic             init_done,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_phase_en,
    input  wire logic [23:0] cmd_phase_word,
    input  wire logic        cmd_cfg_en,
    input  wire logic [23:0] cmd_cfg_word,
    input  wire logic [23:0] cmd_chan_word,
    input  wire logic        cmd_defer,
    input  wire logic        hop_go,
    output logic             busy,
    output logic             diag_level
);

    generate
        if (SCLK_HALF < 1 || STROBE_CYC < 4 || WAIT_CYC < 1) begin : g_chk
            $error("host timing parameters out of range");
        end
    endgenerate

    // =====================================================
    // power-up table
    // =====================================================
    function automatic logic [23:0] init_word(input logic [3:0] step, input logic vb);
        case (step)
            4'h0:    init_word = `W_PD_ALL;
            4'h1:    init_word = `W_FN_GND;
            4'h2:    init_word = `W_TEST_CLR;
            4'h3:    init_word = `W_MODE_DEF;
            4'h4:    init_word = vb ? `W_MODE_DEF : `W_MODE_LD10;
            4'h5:    init_word = `W_TMR_SW12;
            4'h6:    init_word = `W_TMR_SW3;
            4'h7:    init_word = `W_TMR_ICP;
            4'h8:    init_word = `W_PHASE;
            4'h9:    init_word = `W_CFG;
            4'hA:    init_word = `W_CHAN;
            4'hB:    init_word = `W_FN_REL;
            4'hC:    init_word = `W_PD_CLR;
            default: init_word = `W_CHAN;
        endcase
    endfunction

    host_state_s s_reg;
    host_state_s s_next;
    logic [23:0] word;

    always_comb begin
        s_next = s_reg;
        s_next.d_s1 = link.diag_out;
        s_next.d_s2 = s_reg.d_s1;
        // select bits forced so each hop word lands in the right register
        case (s_reg.stage)
            2'h0:    word = {s_reg.ph_w[23:3], `SEL_PHASE};
            2'h1:    word = {s_reg.cfg_w[23:3], `SEL_CFG};
            default: word = {s_reg.ch_w[23:3], `SEL_CHAN};
        endcase
        if (s_reg.init) begin
            word = init_word(s_reg.step, s_reg.vb);
        end

        case (s_reg.st)
            H_IDLE: begin
                s_next.cnt = 32'h0;
                if (start_init) begin
                    s_next.init = 1'b1;
                    s_next.done = 1'b0;
                    s_next.vb = variant_b;
                    s_next.step = 4'h0;
                    s_next.st = H_LOAD;
                end else if (cmd_valid && s_reg.done) begin
                    s_next.ph_w = cmd_phase_word;
                    s_next.cfg_w = cmd_cfg_word;
                    s_next.ch_w = cmd_chan_word;
                    s_next.cfg_en = cmd_cfg_en;
                    s_next.defer = cmd_defer;
                    // phase first, then config, channel always last
                    s_next.stage = cmd_phase_en ? 2'h0 : (cmd_cfg_en ? 2'h1 : 2'h2);
                    s_next.st = H_LOAD;
                end
            end
            H_LOAD: begin
                s_next.sh = word;
                s_next.sdata = word[23];
                s_next.bitn = 5'd23;
                s_next.cnt = 32'h0;
                s_next.st = H_LOW;
            end
            H_LOW: begin
                s_next.cnt = s_reg.cnt + 32'h1;
                if (s_reg.cnt == SCLK_HALF - 1) begin
                    s_next.cnt = 32'h0;
                    s_next.sclk = 1'b1;
                    s_next.st = H_HIGH;
                end
            end
            H_HIGH: begin
                s_next.cnt = s_reg.cnt + 32'h1;
                if (s_reg.cnt == SCLK_HALF - 1) begin
                    s_next.cnt = 32'h0;
                    s_next.sclk = 1'b0;
                    if (s_reg.bitn != 5'd0) begin
                        s_next.bitn = s_reg.bitn - 5'd1;
                        s_next.sh = {s_reg.sh[22:0], 1'b0};
                        s_next.sdata = s_reg.sh[22];
                        s_next.st = H_LOW;
                    end else if (!s_reg.init && s_reg.stage == 2'h2 && s_reg.defer) begin
                        s_next.st = H_HOLD;
                    end else begin
                        s_next.le = 1'b1;
                        s_next.st = H_STROBE;
                    end
                end
            end
            H_HOLD: begin
                if (hop_go) begin
                    s_next.le = 1'b1;
                    s_next.st = H_STROBE;
                end
            end
            H_STROBE: begin
                s_next.cnt = s_reg.cnt + 32'h1;
                if (s_reg.cnt == STROBE_CYC - 1) begin
                    s_next.cnt = 32'h0;
                    s_next.le = 1'b0;
                    s_next.st = H_GAP;
                end
            end
            H_GAP: begin
                s_next.cnt = s_reg.cnt + 32'h1;
                if (s_reg.cnt == STROBE_CYC - 1) begin
                    s_next.cnt = 32'h0;
                    if (s_reg.init) begin
                        if (s_reg.step == 4'h1) begin
                            s_next.st = H_WAIT;
                        end else if (s_reg.step == 4'(`INIT_STEPS - 1)) begin
                            s_next.init = 1'b0;
                            s_next.done = 1'b1;
                            s_next.st = H_IDLE;
                        end else begin
                            s_next.step = s_reg.step + 4'h1;
                            s_next.st = H_LOAD;
                        end
                    end else if (s_reg.stage == 2'h2) begin
                        s_next.st = H_IDLE;
                    end else begin
                        s_next.stage = (s_reg.stage == 2'h0 && s_reg.cfg_en) ? 2'h1 : 2'h2;
                        s_next.st = H_LOAD;
                    end
                end
            end
            H_WAIT: begin
                s_next.cnt = s_reg.cnt + 32'h1;
                if (s_reg.cnt == WAIT_CYC - 1) begin
                    s_next.cnt = 32'h0;
                    s_next.step = 4'h2;
                    s_next.st = H_LOAD;
                end
            end
            default: begin
                s_next.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.st <= H_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.sclk = s_reg.sclk;
    assign link.sdata = s_reg.sdata;
    assign link.latch_strobe = s_reg.le;
    assign init_done = s_reg.done;
    assign cmd_ready = (s_reg.st == H_IDLE) && s_reg.done && !start_init;
    assign busy = (s_reg.st != H_IDLE);
    assign diag_level = s_reg.d_s2;

endmodule

// ### logic/synth_link_cfg.svh
// offsets, field positions, reset values and timing counts of the synthesizer link
`ifndef SYNTH_LINK_CFG_SVH
`define SYNTH_LINK_CFG_SVH

`define WORD_BITS        24
// register select codes, low three bits of every word
`define SEL_CHAN         3'h0
`define SEL_CFG          3'h1
`define SEL_PHASE        3'h2
`define SEL_FUNC         3'h3
`define SEL_TIMER        3'h4
`define SEL_PD           3'h5
`define SEL_MODE         3'h6
`define SEL_TEST         3'h7
// field positions
`define INT_MSB          23
`define INT_LSB          15
`define FRACTION_NUMERATOR_MSB         14
`define FRACTION_NUMERATOR_LSB         3
`define RDIV_MSB         18
`define RDIV_LSB         15
`define BOOST_BIT        23
`define PRESC_BIT        22
`define TMR_SEL_MSB      4
`define TMR_SEL_LSB      3
`define TMR_VAL_MSB      12
`define TMR_VAL_LSB      5
`define FN_RELEASE_BIT   5
`define PD_MSB           7
`define PD_LSB           3
`define MODE_MSB         15
`define MODE_LSB         12
`define MODE_LD10        4'h9
`define TMR_SW12         2'h0
`define TMR_SW3          2'h1
`define TMR_ICP          2'h2
// reset values
`define PD_RESET         5'h1F
`define MOD_RESET        12'h00D
// init words
`define W_PD_ALL         24'h0000FD
`define W_FN_GND         24'h00005B
`define W_TEST_CLR       24'h000007
`define W_MODE_DEF       24'h00000E
`define W_MODE_LD10      24'h00900E
`define W_TMR_SW12       24'h004464
`define W_TMR_SW3        24'h00446C
`define W_TMR_ICP        24'h004394
`define W_PHASE          24'h0000D2
`define W_CFG            24'h520209
`define W_CHAN           24'h480140
`define W_FN_REL         24'h00007B
`define W_PD_CLR         24'h000005
`define INIT_STEPS       14
// timing
`define HOP_DELAY_CYCLES 16
`define CP_RAMP_STEPS    6
`define CP_FULL          8'h40
`define CLK_SYS_MHZ      200
`define INIT_WAIT_MS     10
`define INIT_WAIT_CYCLES (`INIT_WAIT_MS * 1000 * `CLK_SYS_MHZ)
`define SCLK_HALF_CYCLES 4
`define STROBE_CYCLES    8

`endif

// ### logic/synth_link_if.sv
// three-wire write link plus diagnostic return line
`timescale 1ns/1ps
interface synth_link_if;
    logic sclk;
    logic sdata;
    logic latch_strobe;
    logic diag_out;

    modport host (output sclk, output sdata, output latch_strobe, input diag_out);
    modport dev  (input sclk, input sdata, input latch_strobe, output diag_out);
endinterface

// ### logic/synth_link_pkg.sv
// types shared by both ends of the synthesizer serial link
package synth_link_pkg;

    typedef struct packed {
        logic        le_s1;
        logic        le_s2;
        logic        le_s3;
        logic        pend;
        logic [7:0]  dly;
        logic [23:0] cfg_sh;
        logic [11:0] ph_sh;
        logic [23:0] chan;
        logic        rel;
        logic [4:0]  pd;
        logic [3:0]  mode;
        logic [15:0] test;
        logic [7:0]  t_sw12;
        logic [7:0]  t_sw3;
        logic [7:0]  t_icp;
        logic [8:0]  int_a;
        logic [11:0] fraction_numerator_a;
        logic [11:0] mod_a;
        logic [3:0]  rdiv_a;
        logic        boost_a;
        logic        presc_a;
        logic [11:0] acc;
        logic [9:0]  n_div;
        logic [7:0]  fl_cnt;
        logic        fl_run;
        logic        sw12;
        logic        sw3;
        logic [2:0]  cp_sh;
    } dev_state_s;

    typedef enum logic [2:0] {
        H_IDLE, H_LOAD, H_LOW, H_HIGH, H_HOLD, H_STROBE, H_GAP, H_WAIT
    } host_st_e;

    typedef struct packed {
        host_st_e    st;
        logic [23:0] sh;
        logic [4:0]  bitn;
        logic [31:0] cnt;
        logic [3:0]  step;
        logic        init;
        logic        vb;
        logic        done;
        logic [1:0]  stage;
        logic        cfg_en;
        logic        defer;
        logic [23:0] ph_w;
        logic [23:0] cfg_w;
        logic [23:0] ch_w;
        logic        sclk;
        logic        sdata;
        logic        le;
        logic        d_s1;
        logic        d_s2;
    } host_state_s;

endpackage

// ### tb/synth_link_monitor.sv
// checker for the three-wire write link and the fast-lock flag
`timescale 1ns/1ps
module synth_link_monitor (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic latch_strobe,
    input wire logic diag_out
);
    // ==========
    // helper counters: serial bits since last word, cycles since strobe rose
    logic       sclk_q;
    logic       le_q;
    logic [4:0] bit_cnt;
    logic [7:0] since_le;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sclk_q   <= 1'b0;
            le_q     <= 1'b0;
            bit_cnt  <= 5'h00;
            since_le <= 8'hFF;
        end else begin
            sclk_q   <= sclk;
            le_q     <= latch_strobe;
            if (le_q && !latch_strobe) bit_cnt <= 5'h00;
            else if (sclk && !sclk_q) bit_cnt <= bit_cnt + 5'h01;
            if (latch_strobe && !le_q) since_le <= 8'h01;
            else if (since_le != 8'hFF) since_le <= since_le + 8'h01;
        end
    end
    // ==========
    // properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_pulse; latch_strobe[*8]; endsequence
    sequence s_gap; (!latch_strobe && !sclk)[*8]; endsequence
    property p_strobe_frame; $rose(latch_strobe) |-> s_pulse ##1 s_gap; endproperty
    property p_sclk_high; $rose(sclk) |-> sclk[*4] ##1 !sclk; endproperty
    property p_sclk_low; $fell(sclk) |-> !sclk[*4]; endproperty
    property p_data_stable; sclk |-> $stable(sdata); endproperty
    property p_quiet_strobe; latch_strobe |-> !sclk; endproperty
    property p_word_len; $rose(latch_strobe) |-> bit_cnt == 5'd24; endproperty
    property p_hop_cause; $rose(diag_out) |-> since_le inside {[3:26]}; endproperty
    // fast lock flag must drop within 90 cycles of the latest strobe rise
    property p_diag_bound; diag_out |-> since_le <= 8'd90; endproperty
    a_strobe_frame: assert property (p_strobe_frame)
        else $error("strobe pulse or gap length wrong");
    a_sclk_high: assert property (p_sclk_high)
        else $error("serial clock high phase wrong");
    a_sclk_low: assert property (p_sclk_low)
        else $error("serial clock low phase too short");
    a_data_stable: assert property (p_data_stable)
        else $error("serial data moved while clock high");
    a_quiet_strobe: assert property (p_quiet_strobe)
        else $error("serial clock active during strobe");
    a_word_len: assert property (p_word_len)
        else $error("strobe after wrong bit count");
    a_hop_cause: assert property (p_hop_cause)
        else $error("fast lock started without recent strobe");
    a_diag_bound: assert property (p_diag_bound)
        else $error("fast lock ran too long");
endmodule

// ### tb/tb_synth_channel_update_logic.sv
// bench joining the host end and the synthesizer end over the serial link
`timescale 1ns/1ps
`include "synth_link_cfg.svh"
module tb_synth_channel_update_logic;
    import synth_link_pkg::*;
    logic        clk_sys, nrst, start_init, variant_b, init_done, cmd_valid, cmd_ready;
    logic        cmd_phase_en, cmd_cfg_en, cmd_defer, hop_go, busy, diag_level;
    logic [23:0] cmd_phase_word, cmd_cfg_word, cmd_chan_word;
    logic [9:0]  n_div;
    logic [11:0] mod_act;
    logic [3:0]  rdiv_act;
    logic [7:0]  cp_current;
    logic        presc_sel, loop_sw_closed, damp_sw_closed, cp_grounded;
    logic        power_down, ld_thresh_10ns, hop_pending;
    int          err_count, check_count, lat_a, lat_b, k;
    synth_link_if link_if ();
    synth_host #(.WAIT_CYC(50)) synth_host_i (.clk_sys, .nrst, .link(link_if), .start_init,
        .variant_b, .init_done, .cmd_valid, .cmd_ready, .cmd_phase_en, .cmd_phase_word,
        .cmd_cfg_en, .cmd_cfg_word, .cmd_chan_word, .cmd_defer, .hop_go, .busy, .diag_level);
    synth_dev synth_dev_i (.clk_sys, .nrst, .link(link_if), .n_div, .mod_act, .rdiv_act,
        .presc_sel, .cp_current, .loop_sw_closed, .damp_sw_closed, .cp_grounded,
        .power_down, .ld_thresh_10ns, .hop_pending);
    synth_link_monitor synth_link_monitor_i (.clk_sys, .nrst, .sclk(link_if.sclk),
        .sdata(link_if.sdata), .latch_strobe(link_if.latch_strobe), .diag_out(link_if.diag_out));
    // ==========
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic conclude();
        if (err_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic send(input logic ph, input logic cf, input logic [23:0] cfg, input logic dfr);
        for (int i = 0; i < 5000 && !cmd_ready; i++) tick(1);
        cmd_valid = 1'b1;
        cmd_phase_en = ph;
        cmd_cfg_en = cf;
        cmd_cfg_word = cfg;
        cmd_defer = dfr;
        tick(1);
        cmd_valid = 1'b0;
    endtask
    // cycles from the latest strobe rise to the start of fast lock
    task automatic hop_latency(output int n);
        logic q;
        q = 1'b0;
        n = 0;
        for (int i = 0; i < 5000 && link_if.diag_out !== 1'b1; i++) begin
            n = (link_if.latch_strobe && !q) ? 0 : n + 1;
            q = link_if.latch_strobe;
            tick(1);
        end
        check(link_if.diag_out, 1'b1);
    endtask
    // ==========
    // scenarios
    task automatic t_init(input logic vb);
        nrst = 1'b0;
        tick(10);
        nrst = 1'b1;
        start_init = 1'b1;
        variant_b = vb;
        tick(1);
        start_init = 1'b0;
        for (int i = 0; i < 20000 && init_done !== 1'b1; i++) tick(1);
        tick(100);
        check(init_done, 1);
        check(power_down, 0);
        check(cp_grounded, 0);
        check(ld_thresh_10ns, !vb);
        check(mod_act, 65);
        check(rdiv_act, 4);
        check(presc_sel, 1);
    endtask
    task automatic t_fraction();
        k = 0;
        for (int i = 0; i < 65; i++) begin
            k += (n_div == 10'd145);
            tick(1);
        end
        check(k, 40);
    endtask
    task automatic t_fast_lock();
        send(1'b1, 1'b0, 24'h000000, 1'b0);
        hop_latency(lat_a);
        check(cp_current, 8'h40);
        check(hop_pending, 0);
        tick(1);
        check(n_div, 145);
        tick(1);
        check(n_div, 144);
        tick(23);
        check({loop_sw_closed, damp_sw_closed}, 2'b11);
        check(diag_level, 1);
        tick(35);
        check({loop_sw_closed, damp_sw_closed}, 2'b00);
        check(cp_current, 8'h01);
        check(diag_level, 0);
    endtask
    task automatic t_shadow();
        send(1'b0, 1'b1, 24'hC28340, 1'b1);
        tick(900);
        check(mod_act, 65);
        check(rdiv_act, 4);
        check(hop_pending, 0);
        hop_go = 1'b1;
        hop_latency(k);
        check(mod_act, 104);
        check(rdiv_act, 5);
        check(cp_current, 8'h50);
        for (int i = 0; i < 500 && busy !== 1'b0; i++) tick(1);
        check(busy, 0);
        hop_go = 1'b0;
        tick(100);
        send(1'b0, 1'b0, 24'h000000, 1'b0);
        hop_latency(k);
        check(mod_act, 104);
    endtask
    // ==========
    // clock, watchdog, main sequence
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #400us;
        err_count++;
        conclude();
    end
    initial begin
        {nrst, start_init, variant_b, cmd_valid, cmd_phase_en, cmd_cfg_en} = 6'h00;
        {cmd_defer, hop_go} = 2'h0;
        cmd_phase_word = `W_PHASE;
        cmd_cfg_word = `W_CFG;
        cmd_chan_word = `W_CHAN;
        err_count = 0;
        check_count = 0;
        t_init(1'b0);
        t_fraction();
        t_fast_lock();
        t_init(1'b1);
        send(1'b0, 1'b0, 24'h000000, 1'b0);
        hop_latency(lat_b);
        check(lat_b - lat_a, `HOP_DELAY_CYCLES);
        t_shadow();
        conclude();
    end
endmodule
